/* File: rtl/msppm_io.sv */
// Sensor, preset, electrical home, position monitor and alarm reset logic.
// Assumes a motion core on pclk supplying positions and state; APB slave.
//
// Decided for this implementation: the APB slave port and the placing of the registers.
`timescale 1ns/100ps

// Function
// - In homing, either limit input is a homing event for the search.
// - Outside homing a limit stops the motor unless set homing-only.
// - Limit action: -1 home only, 0..3 stop kinds, default 2.
// - Homing mode: 0 two, 1 three sensors, 2 one-way, 3 push; default 1.
// - Home sensor counts only in three-sensor or one-way mode.
// - Slit input, when connected, refines home detection.
// - Preset loads command and feedback positions and saves them.
// - Preset ignored while moving or paused.
// - Preset ignored while deviation flag is set.
// - Electrical home rise captures coordinates; used while input high.
// - Electrical home low returns to mechanical coordinates.
// - Switch in motion converts positions, not the running target.
// - High-speed homing refused while electrical home is high.
// - Monitor request sends data chosen by its own selection.
// - Monitor selection codes 1..4, 8, 9..12; defaults 1 and 8.
// - Outside pulse mode each monitor clock rise shifts the next serial bit out.
// - In pulse mode a monitor clock rise starts transmission.
// - Pulse request rise latches the value to transmit.
// - Pulse data select: 0 cmd, 1 cmd cnt, 2 fb, 3 fb cnt.
// - Pulse rate capped 1..10000 x 0.1 kHz, default 100.
// - Alarm stops motor; cleared only on alarm clear rise.
// - Non-resettable alarms survive an alarm clear rise.
module msppm_io
	import msppm_pkg::*;
(
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Sensor and control pins
	input wire logic forward_limit_in,
	input wire logic reverse_limit_in,
	input wire logic mech_home_sensor_in,
	input wire logic slit_sensor_in,
	input wire logic position_preset_in,
	input wire logic electrical_home_in,
	input wire logic monitor_select_a_in,
	input wire logic monitor_select_b_in,
	input wire logic monitor_shift_clk_in,
	input wire logic pulse_report_request_in,
	input wire logic alarm_clear_in,
	// Monitor pins
	output logic monitor_serial_out,
	output logic pulse_report_out,
	// Motion core state
	input wire logic homing_active,
	input wire logic motor_moving,
	input wire logic pause_active,
	input wire logic deviation_limit_flag,
	input wire logic hs_homing_req,
	input wire logic [31:0] cmd_pos,
	input wire logic [31:0] fb_pos,
	input wire logic [31:0] cmd_cnt,
	input wire logic [31:0] fb_cnt,
	input wire logic alarm_event,
	input wire logic [7:0] alarm_event_code,
	input wire logic alarm_event_fatal,
	// Motion core commands
	output logic homing_limit_event,
	output logic home_ref_hit,
	output logic stop_immediate,
	output logic stop_decel,
	output logic preset_load,
	output logic nvm_write,
	output logic [31:0] preset_value,
	output logic [31:0] cmd_pos_view,
	output logic [31:0] fb_pos_view,
	output logic el_coord_active,
	output logic hs_homing_go,
	output logic alarm_active,
	output logic [7:0] alarm_code
);
`include "msppm_consts.svh"

	// ----------------------------------------
	// Input synchronisers
	// ----------------------------------------
	localparam int NIN = 11;
	logic [NIN-1:0] pin_lvl;
	logic [NIN-1:0] pin_rise;

	msppm_sync #(.WIDTH(NIN)) u_sync (
		.pclk(pclk),
		.presetn(presetn),
		.async_in({alarm_clear_in, pulse_report_request_in, monitor_shift_clk_in,
			monitor_select_b_in, monitor_select_a_in, electrical_home_in,
			position_preset_in, slit_sensor_in, mech_home_sensor_in,
			reverse_limit_in, forward_limit_in}),
		.level(pin_lvl),
		.rise(pin_rise)
	);

	wire lim_lvl = pin_lvl[0] | pin_lvl[1];
	wire lim_rise = pin_rise[0] | pin_rise[1];
	wire mech_home_sensor_in_lvl = pin_lvl[2];
	wire slit_lvl = pin_lvl[3];
	wire preset_rise = pin_rise[4];
	wire el_lvl = pin_lvl[5];
	wire el_rise = pin_rise[5];
	wire mona_rise = pin_rise[6];
	wire monb_rise = pin_rise[7];
	wire mclk_rise = pin_rise[8];
	wire plsreq_rise = pin_rise[9];
	wire almclr_rise = pin_rise[10];

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	msppm_limact_type limact_q;
	msppm_homemode_type homemode_q;
	logic [3:0] monsel_a_q;
	logic [3:0] monsel_b_q;
	logic [1:0] plssel_q;
	logic pulse_mode_q;
	logic slit_en_q;
	logic [31:0] preset_q;
	logic [13:0] plsfreq_q;
	logic [31:0] el_cmd_ofs_q;
	logic [31:0] el_fb_ofs_q;
	logic alarm_q;
	logic alarm_fatal_q;
	logic [7:0] alarm_code_q;
	logic stop_imm_q;
	logic stop_dec_q;
	logic preset_load_q;
	logic [31:0] prdata_q;
	logic mon_left_q;
	logic pg_busy;

	wire apb_setup = psel & ~penable;
	wire apb_acc = psel & penable;
	wire sel_cfg = paddr == `MSPPM_OFS_CONFIG;
	wire sel_pre = paddr == `MSPPM_OFS_PRESET;
	wire sel_frq = paddr == `MSPPM_OFS_PLSFREQ;
	wire sel_sts = paddr == `MSPPM_OFS_STATUS;
	wire sel_ofs = paddr == `MSPPM_OFS_ELOFS;
	wire sel_any = sel_cfg | sel_pre | sel_frq | sel_sts | sel_ofs;
	wire wr_cfg = apb_acc & pwrite & sel_cfg;
	wire wr_pre = apb_acc & pwrite & sel_pre;
	wire wr_frq = apb_acc & pwrite & sel_frq;

	// Only the documented codes are accepted; others keep the old value
	wire [2:0] wla = pwdata[`MSPPM_CF_LIMACT +: 3];
	wire la_ok = wla == 3'b111 || wla[2] == 1'b0;
	wire [3:0] wsa = pwdata[`MSPPM_CF_MONSELA +: 4];
	wire [3:0] wsb = pwdata[`MSPPM_CF_MONSELB +: 4];
	wire sa_ok = (wsa >= 4'h1 && wsa <= 4'h4) || (wsa >= 4'h8 && wsa <= 4'hc);
	wire sb_ok = (wsb >= 4'h1 && wsb <= 4'h4) || (wsb >= 4'h8 && wsb <= 4'hc);
	wire [13:0] wfq = pwdata[13:0];
	wire fq_ok = pwdata[31:14] == 18'h0_0000 && wfq != 14'h0000 && wfq <= `MSPPM_PLSFREQ_MAX;

	wire [31:0] cfg_rd = {12'h000, slit_en_q, pulse_mode_q, plssel_q, monsel_b_q, monsel_a_q,
		2'b00, homemode_q, 1'b0, limact_q};
	wire [31:0] sts_rd = {alarm_code_q, 17'h0_0000, alarm_fatal_q, alarm_q, el_lvl, pg_busy,
		mon_left_q, stop_dec_q, stop_imm_q};
	wire [31:0] rd_mux = sel_cfg ? cfg_rd : sel_pre ? preset_q : sel_frq ? {18'h0_0000, plsfreq_q} :
		sel_sts ? sts_rd : sel_ofs ? el_cmd_ofs_q : 32'h0000_0000;

	assign pready = 1'b1;
	assign pslverr = apb_acc & ~sel_any;
	assign prdata = prdata_q;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			limact_q <= msppm_limact_type'(`MSPPM_RST_LIMACT);
			homemode_q <= msppm_homemode_type'(`MSPPM_RST_HOMEMODE);
			monsel_a_q <= `MSPPM_RST_MONSELA;
			monsel_b_q <= `MSPPM_RST_MONSELB;
			plssel_q <= `MSPPM_RST_PLSSEL;
			pulse_mode_q <= 1'b0;
			slit_en_q <= 1'b0;
			preset_q <= 32'h0000_0000;
			plsfreq_q <= `MSPPM_RST_PLSFREQ;
			prdata_q <= 32'h0000_0000;
		end else begin
			if (apb_setup && !pwrite)
				prdata_q <= rd_mux;
			if (wr_cfg) begin
				if (la_ok)
					limact_q <= msppm_limact_type'(wla);
				homemode_q <= msppm_homemode_type'(pwdata[`MSPPM_CF_HOMEMODE +: 2]);
				if (sa_ok)
					monsel_a_q <= wsa;
				if (sb_ok)
					monsel_b_q <= wsb;
				plssel_q <= pwdata[`MSPPM_CF_PLSSEL +: 2];
				pulse_mode_q <= pwdata[`MSPPM_CF_PULSEMODE];
				slit_en_q <= pwdata[`MSPPM_CF_SLITEN];
			end
			if (wr_pre)
				preset_q <= pwdata;
			if (wr_frq && fq_ok)
				plsfreq_q <= wfq;
		end
	end

	// ----------------------------------------
	// Limits and home sensors
	// ----------------------------------------
	wire ot_enabled = limact_q != MSPPM_LA_HOME_ONLY;
	wire ot_hit = ~homing_active & lim_lvl & ot_enabled;
	wire ot_imm = limact_q == MSPPM_LA_IMM || limact_q == MSPPM_LA_IMM_ALM;
	wire ot_alm = limact_q == MSPPM_LA_IMM_ALM || limact_q == MSPPM_LA_DEC_ALM;
	wire home_used = homemode_q == MSPPM_HM_THREE || homemode_q == MSPPM_HM_ONEWAY;

	assign homing_limit_event = homing_active & lim_rise;
	// Slit qualifies the home sensor only when connected
	assign home_ref_hit = homing_active & home_used & mech_home_sensor_in_lvl & (~slit_en_q | slit_lvl);
	assign stop_immediate = stop_imm_q;
	assign stop_decel = stop_dec_q;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stop_imm_q <= 1'b0;
			stop_dec_q <= 1'b0;
		end else begin
			// Alarm always forces the hard stop
			stop_imm_q <= (ot_hit & ot_imm) | alarm_q;
			stop_dec_q <= ot_hit & ~ot_imm & ~alarm_q;
		end
	end

	// ----------------------------------------
	// Alarm latch
	// ----------------------------------------
	wire ot_alarm_ev = ~homing_active & ot_enabled & ot_alm & lim_rise;
	wire new_alarm = alarm_event | ot_alarm_ev;
	// A held clear level never clears, only its rise does; a new alarm wins over a clear
	wire alarm_clear = almclr_rise & ~alarm_fatal_q;

	assign alarm_active = alarm_q;
	assign alarm_code = alarm_code_q;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			alarm_q <= 1'b0;
			alarm_fatal_q <= 1'b0;
			alarm_code_q <= 8'h00;
		end else if (new_alarm && !alarm_q) begin
			alarm_q <= 1'b1;
			alarm_fatal_q <= alarm_event & alarm_event_fatal;
			alarm_code_q <= alarm_event ? alarm_event_code : `MSPPM_OT_ALARM_CODE;
		end else if (alarm_clear && !new_alarm) begin
			alarm_q <= 1'b0;
			alarm_code_q <= 8'h00;
		end
	end

	// ----------------------------------------
	// Preset and electrical home
	// ----------------------------------------
	wire preset_ok = ~motor_moving & ~pause_active & ~deviation_limit_flag;

	assign preset_load = preset_load_q;
	assign nvm_write = preset_load_q;
	assign preset_value = preset_q;
	assign el_coord_active = el_lvl;
	// Views shift only the present positions; targets stay mechanical in the core
	assign cmd_pos_view = el_lvl ? cmd_pos - el_cmd_ofs_q : cmd_pos;
	assign fb_pos_view = el_lvl ? fb_pos - el_fb_ofs_q : fb_pos;
	assign hs_homing_go = hs_homing_req & ~el_lvl;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			preset_load_q <= 1'b0;
			el_cmd_ofs_q <= 32'h0000_0000;
			el_fb_ofs_q <= 32'h0000_0000;
		end else begin
			preset_load_q <= preset_rise & preset_ok;
			if (el_rise) begin
				el_cmd_ofs_q <= cmd_pos;
				el_fb_ofs_q <= fb_pos;
			end
		end
	end

	// ----------------------------------------
	// Serial position monitor
	// ----------------------------------------
	logic [39:0] mon_sr_q;
	logic [5:0] mon_cnt_q;
	logic monitor_serial_out_q;
	logic [3:0] msel;
	logic [31:0] mpos;
	logic [39:0] mword;
	logic [5:0] mlen;

	// Request A has priority when both rise together
	always_comb begin
		msel = mona_rise ? monsel_a_q : monsel_b_q;
		unique case (msel[1:0])
			2'b01: mpos = fb_pos_view;
			2'b10: mpos = fb_cnt;
			2'b11: mpos = cmd_pos_view;
			default: mpos = cmd_cnt;
		endcase
		if (msel == 4'h8) begin
			mword = {alarm_code_q, 32'h0000_0000};
			mlen = 6'd8;
		end else if (msel[3]) begin
			mword = {mpos, alarm_code_q};
			mlen = `MSPPM_FRAME_LEN;
		end else begin
			mword = {mpos, 8'h00};
			mlen = 6'd32;
		end
	end

	assign monitor_serial_out = monitor_serial_out_q;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mon_sr_q <= 40'h00_0000_0000;
			mon_cnt_q <= 6'd0;
			mon_left_q <= 1'b0;
			monitor_serial_out_q <= 1'b0;
		end else if (!pulse_mode_q && (mona_rise || monb_rise)) begin
			mon_sr_q <= mword;
			mon_cnt_q <= mlen;
			mon_left_q <= 1'b1;
		end else if (!pulse_mode_q && mclk_rise && mon_left_q) begin
			monitor_serial_out_q <= mon_sr_q[39];
			mon_sr_q <= {mon_sr_q[38:0], 1'b0};
			mon_cnt_q <= mon_cnt_q - 6'd1;
			mon_left_q <= mon_cnt_q != 6'd1;
		end
	end

	// ----------------------------------------
	// Pulse request monitor
	// ----------------------------------------
	logic [31:0] pls_val_q;
	wire [31:0] pls_src = plssel_q == 2'b00 ? cmd_pos_view : plssel_q == 2'b01 ? cmd_cnt :
		plssel_q == 2'b10 ? fb_pos_view : fb_cnt;
	// Magnitude only: the burst carries the count, not the sign
	wire [31:0] pls_mag = pls_val_q[31] ? 32'h0000_0000 - pls_val_q : pls_val_q;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			pls_val_q <= 32'h0000_0000;
		else if (plsreq_rise)
			pls_val_q <= pls_src;
	end

	msppm_pulse_gen #(.FREQ_W(14)) u_pg (
		.pclk(pclk),
		.presetn(presetn),
		.start(pulse_mode_q & mclk_rise),
		.count(pls_mag),
		.freq(plsfreq_q),
		.pulse_out(pulse_report_out),
		.busy(pg_busy)
	);

endmodule

/* File: rtl/msppm_consts.svh */
// Offsets, field positions, reset values and timing counts of the sensor/monitor block.
// Assumes inclusion from the design files only.
`ifndef MSPPM_CONSTS_SVH
`define MSPPM_CONSTS_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define MSPPM_OFS_CONFIG 12'h000
`define MSPPM_OFS_PRESET 12'h004
`define MSPPM_OFS_PLSFREQ 12'h008
`define MSPPM_OFS_STATUS 12'h00c
`define MSPPM_OFS_ELOFS 12'h010

// ----------------------------------------
// Config field positions
// ----------------------------------------
`define MSPPM_CF_LIMACT 0
`define MSPPM_CF_HOMEMODE 4
`define MSPPM_CF_MONSELA 8
`define MSPPM_CF_MONSELB 12
`define MSPPM_CF_PLSSEL 16
`define MSPPM_CF_PULSEMODE 18
`define MSPPM_CF_SLITEN 19

// ----------------------------------------
// Reset values
// ----------------------------------------
`define MSPPM_RST_LIMACT 3'b010
`define MSPPM_RST_HOMEMODE 2'b01
`define MSPPM_RST_MONSELA 4'h1
`define MSPPM_RST_MONSELB 4'h8
`define MSPPM_RST_PLSSEL 2'b00
`define MSPPM_RST_PLSFREQ 14'h0064
`define MSPPM_PLSFREQ_MAX 14'h2710
`define MSPPM_OT_ALARM_CODE 8'h66

// ----------------------------------------
// Timing: frequency unit 100 Hz at 50 MHz
// ----------------------------------------
`define MSPPM_CLK_HZ 50000000
`define MSPPM_FREQ_UNIT_HZ 100
`define MSPPM_FRAME_LEN 6'd40

`endif

/* File: rtl/msppm_pkg.sv */
// Types of the sensor/preset/monitor block.
// Assumes nothing beyond a SystemVerilog compiler.
package msppm_pkg;

	typedef enum logic [2:0] {
		MSPPM_LA_HOME_ONLY = 3'b111,
		MSPPM_LA_IMM = 3'b000,
		MSPPM_LA_DEC = 3'b001,
		MSPPM_LA_IMM_ALM = 3'b010,
		MSPPM_LA_DEC_ALM = 3'b011
	} msppm_limact_type;

	typedef enum logic [1:0] {
		MSPPM_HM_TWO = 2'b00,
		MSPPM_HM_THREE = 2'b01,
		MSPPM_HM_ONEWAY = 2'b10,
		MSPPM_HM_PUSH = 2'b11
	} msppm_homemode_type;

	typedef enum logic [1:0] {
		MSPPM_PG_IDLE = 2'b01,
		MSPPM_PG_RUN = 2'b10
	} msppm_pgstate_type;

endpackage

/* File: rtl/msppm_sync.sv */
// Two-flop synchronisers with rising edge detection, one per input bit.
// Assumes asynchronous inputs; edges are found on the second stage only.
`timescale 1ns/100ps

module msppm_sync #(
	parameter int WIDTH = 11
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Raw pins
	input wire logic [WIDTH-1:0] async_in,
	// Synchronised level and rise pulse
	output logic [WIDTH-1:0] level,
	output logic [WIDTH-1:0] rise
);

	genvar i;
	generate
		for (i = 0; i < WIDTH; i++) begin : g_bit
			logic meta_q;
			logic sync_q;
			logic prev_q;
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					meta_q <= 1'b0;
					sync_q <= 1'b0;
					prev_q <= 1'b0;
				end else begin
					meta_q <= async_in[i];
					sync_q <= meta_q;
					prev_q <= sync_q;
				end
			end
			assign level[i] = sync_q;
			assign rise[i] = sync_q & ~prev_q;
		end
	endgenerate

endmodule

/* File: rtl/msppm_pulse_gen.sv */
// Emits a counted burst of pulses at a rate set in 100 Hz units.
// Assumes start is a one-cycle pulse; a start while busy is ignored.
`timescale 1ns/100ps

module msppm_pulse_gen
	import msppm_pkg::*;
#(
	parameter int FREQ_W = 14
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Request
	input wire logic start,
	input wire logic [31:0] count,
	input wire logic [FREQ_W-1:0] freq,
	// Output
	output logic pulse_out,
	output logic busy
);
`include "msppm_consts.svh"

	// Half period in accumulator units: toggles at twice the pulse rate
	localparam logic [23:0] HALF_LIM = 24'(`MSPPM_CLK_HZ / (2 * `MSPPM_FREQ_UNIT_HZ));

	msppm_pgstate_type state_q;
	logic [23:0] acc_q;
	logic [31:0] left_q;
	logic out_q;
	logic [23:0] acc_sum;
	logic tick;

	assign acc_sum = acc_q + 24'(freq);
	assign tick = acc_sum >= HALF_LIM;
	assign pulse_out = out_q;
	assign busy = state_q == MSPPM_PG_RUN;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q <= MSPPM_PG_IDLE;
			acc_q <= 24'h0000;
			left_q <= 32'h0000_0000;
			out_q <= 1'b0;
		end else begin
			unique case (state_q)
				MSPPM_PG_IDLE: begin
					acc_q <= 24'h0000;
					out_q <= 1'b0;
					if (start && count != 32'h0000_0000) begin
						left_q <= count;
						state_q <= MSPPM_PG_RUN;
					end
				end
				MSPPM_PG_RUN: begin
					// Rate ceiling set by the accumulator step
					acc_q <= tick ? acc_sum - HALF_LIM : acc_sum;
					if (tick) begin
						out_q <= ~out_q;
						if (out_q) begin
							left_q <= left_q - 32'h0000_0001;
							if (left_q == 32'h0000_0001)
								state_q <= MSPPM_PG_IDLE;
						end
					end
				end
			endcase
		end
	end

endmodule

/* File: test/msppm_io_sva.sv */
// Port-level properties of the sensor, preset and monitor block.
// Assumes binding onto msppm_io; one clock domain, reset low.
`timescale 1ns/100ps

module msppm_io_sva (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Pins
	input wire logic forward_limit_in,
	input wire logic reverse_limit_in,
	input wire logic monitor_select_a_in,
	input wire logic monitor_select_b_in,
	input wire logic monitor_shift_clk_in,
	input wire logic alarm_clear_in,
	input wire logic monitor_serial_out,
	// Core side
	input wire logic homing_active,
	input wire logic motor_moving,
	input wire logic pause_active,
	input wire logic deviation_limit_flag,
	input wire logic hs_homing_req,
	input wire logic [31:0] cmd_pos,
	input wire logic homing_limit_event,
	input wire logic stop_immediate,
	input wire logic stop_decel,
	input wire logic preset_load,
	input wire logic nvm_write,
	input wire logic [31:0] cmd_pos_view,
	input wire logic el_coord_active,
	input wire logic hs_homing_go,
	input wire logic alarm_active
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	// ----
	// Sequences
	// ----
	// Five samples outlast the sync pipe and edge register
	sequence s_limits_idle;
		(!forward_limit_in && !reverse_limit_in && !alarm_active) [*5];
	endsequence
	sequence s_link_quiet;
		($stable(monitor_shift_clk_in) && !monitor_select_a_in && !monitor_select_b_in) [*5];
	endsequence

	// ----
	// Properties
	// ----
	a_limit_homing_event: assert property (homing_limit_event |-> homing_active
		&& ($past(forward_limit_in, 2) || $past(reverse_limit_in, 2)) ##1 !homing_limit_event)
		else $error("homing event without limit rise");
	a_limit_quiet_stop: assert property (s_limits_idle |-> !stop_immediate && !stop_decel)
		else $error("stop without limit or alarm");
	a_alarm_hold: assert property ((alarm_active && !alarm_clear_in) [*4] |=> alarm_active)
		else $error("alarm dropped without clear edge");
	a_preset_gate: assert property (preset_load |-> !$past(motor_moving)
		&& !$past(pause_active) && !$past(deviation_limit_flag))
		else $error("preset taken while blocked");
	a_preset_pulse: assert property (preset_load |-> nvm_write ##1 !preset_load)
		else $error("preset pulse malformed");
	a_hs_homing_block: assert property (hs_homing_go == (hs_homing_req && !el_coord_active))
		else $error("fast homing gate wrong");
	a_mech_view: assert property (!el_coord_active |-> cmd_pos_view == cmd_pos)
		else $error("mechanical view differs");
	a_serial_hold: assert property (s_link_quiet |=> $stable(monitor_serial_out))
		else $error("serial bit moved without clock");
endmodule

bind msppm_io msppm_io_sva msppm_io_sva_inst (.*);

/* File: test/msppm_host_model.sv */
// Host side of the monitor link: makes the shift clock, counts pulses.
// Assumes the bench calls its tasks; the clock idles low between frames.
`timescale 1ns/100ps

module msppm_host_model (
	// From the block
	input wire logic monitor_serial_out,
	input wire logic pulse_report_out,
	// To the block
	output logic monitor_shift_clk_in
);
	int pulse_count;

	initial begin
		monitor_shift_clk_in = 1'b0;
		pulse_count = 0;
	end

	always @(posedge pulse_report_out) begin
		pulse_count++;
	end

	// Bit taken just before the next rise, long after it settled
	task automatic shift_frame(input int nbits, input int half_ns, output logic [39:0] word);
		word = '0;
		#7;
		for (int i = 0; i < nbits; i++) begin
			monitor_shift_clk_in = 1'b1;
			#(half_ns);
			monitor_shift_clk_in = 1'b0;
			#(half_ns);
			word = {word[38:0], monitor_serial_out};
		end
	endtask

	task automatic start_burst();
		#7;
		monitor_shift_clk_in = 1'b1;
		#80;
		monitor_shift_clk_in = 1'b0;
		#80;
	endtask
endmodule

/* File: test/msppm_io_tb.sv */
// Self-checking bench for the sensor, preset and monitor block.
// Assumes the host model on the monitor link and the bound checker.
`timescale 1ns/100ps

module msppm_io_tb;
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, e;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = '0, prdata, r, v, cmd_pos = '0, fb_pos = '0, cmd_cnt = '0, fb_cnt = '0;
	logic [31:0] preset_value, cmd_pos_view, fb_pos_view;
	logic [8:0] pins = 9'h000;
	logic slit_sensor_in = 1'b0, homing_active = 1'b0, motor_moving = 1'b0, pause_active = 1'b0;
	logic deviation_limit_flag = 1'b0, hs_homing_req = 1'b0, alarm_event = 1'b0, alarm_event_fatal = 1'b0;
	logic [7:0] alarm_event_code = 8'h00, alarm_code;
	logic forward_limit_in, reverse_limit_in, mech_home_sensor_in, position_preset_in, electrical_home_in;
	logic monitor_select_a_in, monitor_select_b_in, monitor_shift_clk_in, pulse_report_request_in, alarm_clear_in;
	logic monitor_serial_out, pulse_report_out, homing_limit_event, home_ref_hit, stop_immediate, stop_decel;
	logic preset_load, nvm_write, el_coord_active, hs_homing_go, alarm_active;
	logic [39:0] w;
	logic [31:0] src [4];
	logic [2:0] acts [5] = '{3'b111, 3'b000, 3'b001, 3'b010, 3'b011};
	logic [2:0] outs [5] = '{3'b000, 3'b100, 3'b010, 3'b101, 3'b101};
	int num_errors = 0, num_checks = 0, loads = 0, events = 0, n;

	assign {mech_home_sensor_in, alarm_clear_in, pulse_report_request_in, monitor_select_b_in, monitor_select_a_in,
		position_preset_in, electrical_home_in, reverse_limit_in, forward_limit_in} = pins;

	msppm_io msppm_io_inst (.*);
	msppm_host_model msppm_host_model_inst (.monitor_serial_out(monitor_serial_out),
		.pulse_report_out(pulse_report_out), .monitor_shift_clk_in(monitor_shift_clk_in));

	always #10 pclk = ~pclk;
	always @(posedge pclk) begin
		loads <= loads + int'(preset_load === 1'b1);
		events <= events + int'(homing_limit_event === 1'b1);
	end

	// ----
	// Tasks
	// ----
	task automatic tally_and_finish();
		$display("checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic chk_bit(input logic got, input logic exp);
		chk({31'h0, got}, {31'h0, exp});
	endtask
	task automatic cyc(input int k);
		repeat (k) @(posedge pclk);
	endtask
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int k;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1 && k < 16);
		if (k >= 16) begin
			num_errors++;
			tally_and_finish();
		end
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0000_0000);
		chk(r, exp);
	endtask
	// Five cycles clear the sync pipe and edge register
	task automatic pin(input int i, input logic val);
		pins[i] <= val;
		cyc(5);
	endtask
	task automatic pulse(input int i);
		pin(i, 1'b1);
		pin(i, 1'b0);
	endtask

	// ----
	// Scenarios
	// ----
	initial begin
		v = $urandom(32'h1f5a);
		cyc(2);
		presetn <= 1'b1;
		cyc(3);
		rd(12'h000, 32'h0000_8112);
		rd(12'h008, 32'h0000_0064);
		apb(1'b1, 12'h008, 32'h0000_0000);
		rd(12'h008, 32'h0000_0064);
		apb(1'b1, 12'h008, 32'h0000_2711);
		rd(12'h008, 32'h0000_0064);
		apb(1'b1, 12'h008, 32'h0000_2710);
		rd(12'h008, 32'h0000_2710);
		rd(12'h014, 32'h0000_0000);
		chk_bit(e, 1'b1);
		// Clear held high before the alarm must not clear it
		for (int a = 0; a < 5; a++) begin
			apb(1'b1, 12'h000, 32'h0000_8110 | 32'(acts[a]));
			pin(7, 1'b1);
			pin(0, 1'b1);
			chk({29'h0, stop_immediate, stop_decel, alarm_active}, {29'h0, outs[a]});
			if (outs[a][0]) begin
				chk({24'h0, alarm_code}, 32'h0000_0066);
			end
			pin(0, 1'b0);
			chk_bit(alarm_active, outs[a][0]);
			pin(7, 1'b0);
			pulse(7);
			chk_bit(alarm_active, 1'b0);
		end
		apb(1'b1, 12'h000, 32'h0000_8112);
		homing_active <= 1'b1;
		pulse(1);
		chk(events, 1);
		chk_bit(stop_immediate, 1'b0);
		pin(8, 1'b1);
		chk_bit(home_ref_hit, 1'b1);
		apb(1'b1, 12'h000, 32'h0008_8112);
		cyc(1);
		chk_bit(home_ref_hit, 1'b0);
		slit_sensor_in <= 1'b1;
		cyc(5);
		chk_bit(home_ref_hit, 1'b1);
		apb(1'b1, 12'h000, 32'h0000_8102);
		cyc(1);
		chk_bit(home_ref_hit, 1'b0);
		pin(8, 1'b0);
		homing_active <= 1'b0;
		v = $urandom;
		apb(1'b1, 12'h004, v);
		rd(12'h004, v);
		chk(preset_value, v);
		for (int c = 0; c < 4; c++) begin
			{deviation_limit_flag, pause_active, motor_moving} <= 3'b100 >> (3 - c);
			pulse(3);
			chk(loads, 1);
		end
		// Electrical home taken while moving
		{deviation_limit_flag, pause_active, motor_moving} <= 3'b001;
		v = $urandom;
		cmd_pos <= v;
		fb_pos <= ~v;
		hs_homing_req <= 1'b1;
		pin(2, 1'b1);
		chk_bit(el_coord_active, 1'b1);
		chk_bit(hs_homing_go, 1'b0);
		cmd_pos <= v + 32'h0000_0123;
		cyc(2);
		chk(cmd_pos_view, 32'h0000_0123);
		chk(fb_pos_view, 32'h0000_0000);
		rd(12'h010, v);
		pin(2, 1'b0);
		chk(cmd_pos_view, v + 32'h0000_0123);
		chk_bit(hs_homing_go, 1'b1);
		hs_homing_req <= 1'b0;
		motor_moving <= 1'b0;
		v = $urandom;
		alarm_event_code <= v[7:0];
		alarm_event_fatal <= 1'b1;
		alarm_event <= 1'b1;
		cyc(1);
		alarm_event <= 1'b0;
		pulse(7);
		chk_bit(alarm_active, 1'b1);
		chk({24'h0, alarm_code}, {24'h0, v[7:0]});
		rd(12'h00c, {v[7:0], 24'h00_0061});
		pulse(5);
		msppm_host_model_inst.shift_frame(8, 80, w);
		chk(w[31:0], {24'h0, v[7:0]});
		// Only a reset drops a fatal alarm
		presetn <= 1'b0;
		cyc(2);
		presetn <= 1'b1;
		cyc(3);
		chk_bit(alarm_active, 1'b0);
		foreach (src[i]) src[i] = $urandom;
		{fb_pos, fb_cnt, cmd_pos, cmd_cnt} <= {src[0], src[1], src[2], src[3]};
		for (int k = 0; k < 8; k++) begin
			n = k < 4 ? k + 1 : k + 5;
			apb(1'b1, 12'h000, 32'h0000_8012 | (32'(n) << 8));
			pulse(4);
			msppm_host_model_inst.shift_frame(n > 8 ? 40 : 32, 80, w);
			chk(n > 8 ? w[39:8] : w[31:0], src[(n - 1) % 4]);
		end
		apb(1'b1, 12'h008, 32'h0000_2710);
		apb(1'b1, 12'h000, 32'h0006_8112);
		n = $urandom_range(8, 1);
		fb_pos <= 32'(n);
		pulse(6);
		fb_pos <= 32'h0000_0040;
		msppm_host_model_inst.start_burst();
		cyc(n * 50 + 60);
		chk(msppm_host_model_inst.pulse_count, n);
		tally_and_finish();
	end
endmodule
